/* File: src/prt_timer.sv */
// prt_timer: apb register file around the cascaded reload timer.
// assumes: apb master per amba apb; protocol events arrive as one-cycle pulses on CLK.
//
// How it works
// - the timer steps on a 13.56 MHz base derived from the system clock.
// - first stage is a 12-bit prescaler, reload 0..4095 over two registers.
// - second stage is a counter with a 16-bit reload value 0..65535.
// - the live counter value is readable in its own register.
// - reaching zero sets the timer flag in the common interrupt register.
// - with its enable set, the zero event drives the interrupt output.
// - software may both set and clear the timer flag.
// - at zero the timer either halts or reloads and continues, by configuration.
// - a running bit in the first status register shows counting.
// - start-now starts the timer at once, stop-now halts it at once unless start-now or an auto-start event comes in the same cycle.
// - with auto-start set, protocol events start the timer without a write.
// - the counter stage delays its reload value plus one prescaler steps when reloading.
// - prescaler period is twice value plus one, or plus two when even.
// - the timer drives nothing but its own flag and interrupt line.
// - the flag rises the clock after the counter goes from one to zero, or steps at zero in one-shot mode or with a zero reload.
`timescale 1ns/1ps
module prt_timer (
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // protocol events that may auto-start the timer
    input wire logic PROTO_EVENT,
    // interrupt request line
    output logic IRQ
);
    import prt_pkg::*;

    logic [7:0] timer_mode_reg, next_timer_mode_reg;
    logic [7:0] prescale_low_reg, next_prescale_low_reg;
    logic [15:0] count_reload_reg, next_count_reload_reg;
    logic timer_zero_flag, next_timer_zero_flag;
    logic irq_en, next_irq_en;
    logic [31:0] next_prdata;
    logic start_pulse, next_start_pulse;
    logic stop_pulse, next_stop_pulse;
    logic [17:0] phase, next_phase;
    logic base_tick, next_base_tick;
    logic irq_q, next_irq_q;
    logic wr, rd, hit;
    prt_cfg_s cfg;
    prt_stat_s stat;

    assign wr = PSEL && PENABLE && PWRITE;
    // read data is captured in the setup cycle so that it stands through the access phase
    assign rd = PSEL && !PENABLE && !PWRITE;
    assign hit = (PADDR == OFS_TIMER_MODE) || (PADDR == OFS_PRESCALE_LOW) || (PADDR == OFS_COUNT_RELOAD)
        || (PADDR == OFS_COUNT_VALUE) || (PADDR == OFS_COMMON_IRQ) || (PADDR == OFS_FIRST_STATUS)
        || (PADDR == OFS_CONTROL) || (PADDR == OFS_IRQ_ENABLE);
    // zero-wait slave; unmapped addresses answer with an error
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !hit;

    // 13.56 MHz base tick by phase accumulation; jitter of one clock is the price
    always_comb begin
        next_phase = phase + BASE_STEP;
        next_base_tick = 1'b0;
        if (next_phase >= BASE_WRAP) begin
            next_phase = next_phase - BASE_WRAP;
            next_base_tick = 1'b1;
        end
    end

    // register writes, flag update and read mux
    always_comb begin
        next_timer_mode_reg = timer_mode_reg;
        next_prescale_low_reg = prescale_low_reg;
        next_count_reload_reg = count_reload_reg;
        next_irq_en = irq_en;
        next_timer_zero_flag = timer_zero_flag;
        next_start_pulse = 1'b0;
        next_stop_pulse = 1'b0;
        next_prdata = 32'h0000_0000;
        if (wr) begin
            case (PADDR)
                OFS_TIMER_MODE: next_timer_mode_reg = PWDATA[7:0];
                OFS_PRESCALE_LOW: next_prescale_low_reg = PWDATA[7:0];
                OFS_COUNT_RELOAD: next_count_reload_reg = PWDATA[15:0];
                OFS_COMMON_IRQ: begin
                    // bit 7 selects whether marked bits are set or cleared
                    if (PWDATA[IRQ_TIMER_BIT]) begin
                        next_timer_zero_flag = PWDATA[IRQ_SET_BIT];
                    end
                end
                OFS_CONTROL: begin
                    next_stop_pulse = PWDATA[CTRL_STOP_BIT];
                    next_start_pulse = PWDATA[CTRL_START_BIT];
                end
                OFS_IRQ_ENABLE: next_irq_en = PWDATA[IRQ_TIMER_BIT];
                default: ;
            endcase
        end
        if (PROTO_EVENT && timer_mode_reg[MODE_AUTO_BIT]) begin
            next_start_pulse = 1'b1;
        end
        // hardware set wins over a clear in the same cycle
        if (stat.zero_evt) begin
            next_timer_zero_flag = 1'b1;
        end
        if (rd) begin
            case (PADDR)
                OFS_TIMER_MODE: next_prdata = {24'h000000, timer_mode_reg};
                OFS_PRESCALE_LOW: next_prdata = {24'h000000, prescale_low_reg};
                OFS_COUNT_RELOAD: next_prdata = {16'h0000, count_reload_reg};
                OFS_COUNT_VALUE: next_prdata = {16'h0000, stat.count};
                OFS_COMMON_IRQ: next_prdata = {31'h00000000, timer_zero_flag};
                OFS_FIRST_STATUS: next_prdata = 32'(stat.running) << STAT_RUN_BIT;
                OFS_IRQ_ENABLE: next_prdata = {31'h00000000, irq_en};
                default: next_prdata = 32'h0000_0000;
            endcase
        end
        // the line follows the flag only; no other function is touched
        next_irq_q = irq_en && next_timer_zero_flag;
    end

    assign cfg.pre_reload = {timer_mode_reg[MODE_PRE_HI_LSB +: MODE_PRE_HI_W], prescale_low_reg};
    assign cfg.cnt_reload = count_reload_reg;
    assign cfg.restart = timer_mode_reg[MODE_RESTART_BIT];
    assign cfg.even = timer_mode_reg[MODE_EVEN_BIT];

    // registers of the bus side
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            timer_mode_reg <= MODE_RST;
            prescale_low_reg <= PRE_LOW_RST;
            count_reload_reg <= RELOAD_RST;
            timer_zero_flag <= 1'b0;
            irq_en <= 1'b0;
            PRDATA <= 32'h0000_0000;
            start_pulse <= 1'b0;
            stop_pulse <= 1'b0;
            phase <= 18'h00000;
            base_tick <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            timer_mode_reg <= next_timer_mode_reg;
            prescale_low_reg <= next_prescale_low_reg;
            count_reload_reg <= next_count_reload_reg;
            timer_zero_flag <= next_timer_zero_flag;
            irq_en <= next_irq_en;
            PRDATA <= next_prdata;
            start_pulse <= next_start_pulse;
            stop_pulse <= next_stop_pulse;
            phase <= next_phase;
            base_tick <= next_base_tick;
            irq_q <= next_irq_q;
        end
    end

    assign IRQ = irq_q;

    prt_core u_core (
        .clk(CLK),
        .arst_n(ARST_N),
        .base_tick(base_tick),
        .start(start_pulse),
        .stop(stop_pulse),
        .cfg(cfg),
        .stat(stat)
    );
endmodule // prt_timer

/* File: src/prt_pkg.sv */
// prt_pkg: constants, register map and carrier types for the prescaled reload timer.
// assumes: a 200 MHz system clock; the 13.56 MHz timer base arrives as a one-cycle tick.
package prt_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] OFS_TIMER_MODE = 8'h00;
    localparam logic [7:0] OFS_PRESCALE_LOW = 8'h04;
    localparam logic [7:0] OFS_COUNT_RELOAD = 8'h08;
    localparam logic [7:0] OFS_COUNT_VALUE = 8'h0C;
    localparam logic [7:0] OFS_COMMON_IRQ = 8'h10;
    localparam logic [7:0] OFS_FIRST_STATUS = 8'h14;
    localparam logic [7:0] OFS_CONTROL = 8'h18;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1C;
    // timer mode register fields
    localparam int MODE_AUTO_BIT = 7;
    localparam int MODE_RESTART_BIT = 4;
    localparam int MODE_EVEN_BIT = 5;
    localparam int MODE_PRE_HI_LSB = 0;
    localparam int MODE_PRE_HI_W = 4;
    // flag positions
    localparam int IRQ_TIMER_BIT = 0;
    localparam int IRQ_SET_BIT = 7;
    localparam int STAT_RUN_BIT = 3;
    localparam int CTRL_STOP_BIT = 7;
    localparam int CTRL_START_BIT = 6;
    // widths and reset values
    localparam int PRE_W = 12;
    localparam int CNT_W = 16;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] PRE_LOW_RST = 8'h00;
    localparam logic [15:0] RELOAD_RST = 16'h0000;
    // timer base: 13.56 MHz from the 200 MHz clock by phase accumulation
    localparam int CLK_KHZ = 200000;
    localparam int BASE_KHZ = 13560;
    localparam logic [17:0] BASE_STEP = 18'(BASE_KHZ);
    localparam logic [17:0] BASE_WRAP = 18'(CLK_KHZ);

    // settings that the counting core needs
    typedef struct packed {
        logic [PRE_W-1:0] pre_reload;
        logic [CNT_W-1:0] cnt_reload;
        logic restart;
        logic even;
    } prt_cfg_s;

    // core status back to the register file
    typedef struct packed {
        logic running;
        logic zero_evt;
        logic [CNT_W-1:0] count;
    } prt_stat_s;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } prt_state_e;
endpackage

/* File: src/prt_core.sv */
// prt_core: two-stage cascaded down-counter clocked by the 13.56 MHz base tick.
// assumes: start/stop are one-cycle pulses; base_tick is one cycle wide.
`timescale 1ns/1ps
module prt_core (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // control
    input wire logic base_tick,
    input wire logic start,
    input wire logic stop,
    input wire prt_pkg::prt_cfg_s cfg,
    // status
    output prt_pkg::prt_stat_s stat
);
    import prt_pkg::*;

    prt_state_e state, next_state;
    logic [PRE_W-1:0] pre;
    logic [PRE_W-1:0] next_pre;
    logic half;
    logic next_half;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic zero_evt;
    logic next_zero_evt;

    // prescaler period is 2*value+1 base steps, or 2*value+2 when even is set
    always_comb begin
        next_state = state;
        next_pre = pre;
        next_half = half;
        next_cnt = cnt;
        next_zero_evt = 1'b0;
        if (start) begin
            next_state = ST_RUN;
            next_pre = cfg.pre_reload;
            next_half = 1'b0;
            next_cnt = cfg.cnt_reload;
        end else if (stop) begin
            next_state = ST_IDLE;
        end else if (state == ST_RUN && base_tick) begin
            // first pass takes value+1 steps, the second value (odd) or value+1 (even) steps
            if (pre != '0) begin
                next_pre = pre - 1'b1;
            end else if (!half && (cfg.even || cfg.pre_reload != '0)) begin
                next_half = 1'b1;
                next_pre = cfg.even ? cfg.pre_reload : cfg.pre_reload - 1'b1;
            end else begin
                next_half = 1'b0;
                next_pre = cfg.pre_reload;
                // prescaler underflow steps the counter stage
                if (cnt == 16'h0001) begin
                    next_cnt = 16'h0000;
                    next_zero_evt = 1'b1;
                    if (!cfg.restart) begin
                        next_state = ST_IDLE;
                    end
                end else if (cnt == 16'h0000) begin
                    // the step out of zero is the extra one of reload plus one
                    if (cfg.restart) begin
                        next_cnt = cfg.cnt_reload;
                        next_zero_evt = (cfg.cnt_reload == 16'h0000);
                    end else begin
                        // started at zero: report it and halt
                        next_zero_evt = 1'b1;
                        next_state = ST_IDLE;
                    end
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
        end
    end

    // state registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            pre <= '0;
            half <= 1'b0;
            cnt <= '0;
            zero_evt <= 1'b0;
        end else begin
            state <= next_state;
            pre <= next_pre;
            half <= next_half;
            cnt <= next_cnt;
            zero_evt <= next_zero_evt;
        end
    end

    assign stat.running = (state == ST_RUN);
    assign stat.zero_evt = zero_evt;
    assign stat.count = cnt;
endmodule // prt_core

/* File: bench/prt_timer_asserts.sv */
// prt_timer_asserts: port-level checks on the apb timer.
// assumes: bound to prt_timer; one clock, async active-low reset.
`timescale 1ns/1ps
module prt_timer_asserts (
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PSLVERR,
    // interrupt
    input wire logic IRQ
);
    import prt_pkg::*;
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    logic acc;
    logic irq_wr;
    logic en;
    logic next_en;
    assign acc = PSEL && PENABLE;
    assign irq_wr = acc && PWRITE && PADDR == OFS_COMMON_IRQ && PWDATA[IRQ_TIMER_BIT];
    // mirror of the enable bit, because the gate behind IRQ is not visible
    always_comb next_en = (acc && PWRITE && PADDR == OFS_IRQ_ENABLE) ? PWDATA[0] : en;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) en <= 1'b0;
        else en <= next_en;
    end
    sequence start_wr; acc && PWRITE && PADDR == OFS_CONTROL && PWDATA[CTRL_START_BIT]; endsequence
    sequence stop_wr;
        acc && PWRITE && PADDR == OFS_CONTROL && PWDATA[CTRL_STOP_BIT] && !PWDATA[CTRL_START_BIT];
    endsequence
    sequence stat_rd; acc && !PWRITE && PADDR == OFS_FIRST_STATUS; endsequence
    a_rdata_idle: assert property (!(PSEL && !PENABLE && !PWRITE) |=> PRDATA == 32'h0)
        else $error("read data kept");
    a_rdata_width: assert property (PSEL && !PENABLE |=> PRDATA[31:16] == 16'h0)
        else $error("upper bits set");
    a_hole_error: assert property (acc && PADDR > OFS_IRQ_ENABLE |-> PSLVERR) else $error("no slave error");
    a_flag_clear: assert property (irq_wr && !PWDATA[IRQ_SET_BIT] |-> ##2 !IRQ) else $error("irq kept");
    a_flag_set: assert property (irq_wr && PWDATA[IRQ_SET_BIT] && en |-> ##2 IRQ) else $error("irq missing");
    a_irq_gated: assert property (!en && !$past(en) |-> !IRQ) else $error("irq while disabled");
    a_start_runs: assert property (start_wr ##3 stat_rd |-> PRDATA[STAT_RUN_BIT]) else $error("not running");
    a_stop_halts: assert property (stop_wr ##3 stat_rd |-> !PRDATA[STAT_RUN_BIT]) else $error("still running");
endmodule // prt_timer_asserts
bind prt_timer prt_timer_asserts u_chk (.CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PSLVERR, .IRQ);

/* File: bench/tb_top.sv */
// tb_top: apb bench for the prescaled reload timer.
// assumes: zero-wait apb, read data standing through the access phase.
`timescale 1ns/1ps
module tb_top;
    import prt_pkg::*;
    logic CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic PROTO_EVENT = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic IRQ;
    logic [31:0] rdat;
    logic slv;
    int failures = 0;
    int tests_run = 0;
    int n;
    int e;
    int x;
    always #2.5 CLK = ~CLK;
    prt_timer u_dut (.CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
        .PROTO_EVENT, .IRQ);
    // one apb transfer; a new one always waits for the next edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        // response and read data are taken at the ready edge itself
        slv = PSLVERR;
        rdat = PRDATA;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask
    // bounded wait; a miss shows up as a count out of range
    task automatic wait_irq();
        n = 0;
        while (IRQ !== 1'b1 && n < 4000) begin
            @(posedge CLK);
            n++;
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge CLK);
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge CLK);
        ARST_N <= 1'b1;
        rd(OFS_TIMER_MODE, 32'h0);
        rd(OFS_COUNT_RELOAD, 32'h0);
        rd(OFS_FIRST_STATUS, 32'h0);
        rd(8'h40, 32'h0);
        chk(32'(slv), 32'h1);
        xfer(1'b1, OFS_PRESCALE_LOW, 32'h02);
        xfer(1'b1, OFS_COUNT_RELOAD, 32'h03);
        xfer(1'b1, OFS_IRQ_ENABLE, 32'h01);
        // one-shot, odd then even prescale
        for (e = 0; e < 2; e++) begin
            xfer(1'b1, OFS_TIMER_MODE, 32'(e * 32));
            rd(OFS_TIMER_MODE, 32'(e * 32));
            xfer(1'b1, OFS_CONTROL, 32'h40);
            rd(OFS_FIRST_STATUS, 32'h08);
            wait_irq();
            x = (5 + e) * 3 * CLK_KHZ / BASE_KHZ; // 5 or 6 base ticks per step, 3 steps down to zero
            chk(32'(n > x - 20 && n < x + 20), 32'h1);
            rd(OFS_COUNT_VALUE, 32'h0);
            rd(OFS_FIRST_STATUS, 32'h0);
            rd(OFS_COMMON_IRQ, 32'h01);
            xfer(1'b1, OFS_COMMON_IRQ, 32'h01);
            rd(OFS_COMMON_IRQ, 32'h0);
            chk(32'(IRQ), 32'h0);
        end
        xfer(1'b1, OFS_COMMON_IRQ, 32'h81);
        rd(OFS_COMMON_IRQ, 32'h01);
        chk(32'(IRQ), 32'h1);
        xfer(1'b1, OFS_IRQ_ENABLE, 32'h0);
        rd(OFS_IRQ_ENABLE, 32'h0);
        chk(32'(IRQ), 32'h0);
        xfer(1'b1, OFS_COMMON_IRQ, 32'h01);
        xfer(1'b1, OFS_IRQ_ENABLE, 32'h01);
        // periodic mode, then stop in mid-run
        xfer(1'b1, OFS_TIMER_MODE, 32'h10);
        xfer(1'b1, OFS_CONTROL, 32'h40);
        wait_irq();
        xfer(1'b1, OFS_COMMON_IRQ, 32'h01);
        rd(OFS_FIRST_STATUS, 32'h08);
        wait_irq();
        chk(32'(n > 260 && n < 310), 32'h1);
        xfer(1'b1, OFS_CONTROL, 32'h80);
        rd(OFS_FIRST_STATUS, 32'h0);
        // protocol event starts the timer only with auto-start set
        for (e = 0; e < 2; e++) begin
            xfer(1'b1, OFS_TIMER_MODE, 32'(e * 128));
            @(posedge CLK);
            PROTO_EVENT <= 1'b1;
            @(posedge CLK);
            PROTO_EVENT <= 1'b0;
            rd(OFS_FIRST_STATUS, 32'(e * 8));
        end
        report_and_stop();
    end
endmodule // tb_top
